// ### src/asr_ctrl.sv
`timescale 1ns/1ns
module asr_ctrl
    import asr_pkg::*;
#(
    parameter int unsigned RATE_W_P = RATE_W,
    parameter int unsigned PULSE_CLKS_P = UPD_PULSE_CLKS
) (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Master clock passthrough.
    input wire logic i_mclk,
    output logic o_mclk,
    // Control writes from the serial front end.
    input wire logic i_ctl_we,
    input wire logic i_sync_wdata,
    input wire logic i_standby_bit_wdata,
    input wire logic [RATE_W_P-1:0] i_rate_clks,
    input wire logic i_rate_we,
    // Completion of a data register read.
    input wire logic i_data_read_done,
    // Converter side.
    output logic o_filter_reset,
    output logic o_powered_down,
    output logic o_load_word,
    // Status.
    output logic o_data_ready_n,
    output logic o_status_msb,
    output logic o_filter_sync_bit,
    output logic o_standby_bit
);

    // =========================================================================
    // Checks
    // =========================================================================
    // The pulse counter and the settle counter are sized by the package.
    // Refuse settings that would wrap them, since a wrapped counter would
    // silently shorten the high pulse or skip a settling period.
    initial begin
        if (PULSE_CLKS_P < 2 || PULSE_CLKS_P >= (1 << PULSE_W))
            $error("asr_ctrl: PULSE_CLKS_P out of range");
        if (RATE_W_P < 2)
            $error("asr_ctrl: RATE_W_P too small");
        if (SETTLE_PERIODS < 1 || SETTLE_PERIODS > (1 << SETTLE_W))
            $error("asr_ctrl: settle count does not fit");
    end

    // =========================================================================
    // Divider
    // =========================================================================
    // The divider turns the master clock into one tick per output period.
    // It only runs while the sequencer asks for it, so every restart of
    // conversion counts its settling periods from a clean zero.
    // A new period takes effect at once, compared against the count already running.
    asr_tick_if tk ();
    logic [RATE_W_P-1:0] rate_q, rate_d;

    asr_rate_div #(
        .RATE_W_P(RATE_W_P)
    ) u_div (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_period(rate_q),
        .tk(tk)
    );

    // =========================================================================
    // Control bits
    // =========================================================================
    // The front end decodes the serial frames; this block only sees the
    // resulting write strobes. The period register is kept separately so a
    // control write never disturbs the configured rate.
    logic sync_q, sync_d;
    logic standby_bit_q, standby_bit_d;

    // Writes only take effect out of reset, so accesses in reset are lost.
    always_comb begin
        sync_d = sync_q;
        standby_bit_d = standby_bit_q;
        rate_d = rate_q;
        if (i_ctl_we) begin
            sync_d = i_sync_wdata;
            standby_bit_d = i_standby_bit_wdata;
        end
        if (i_rate_we) begin
            rate_d = i_rate_clks;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sync_q <= SYNC_RST;
            standby_bit_q <= STANDBY_BIT_RST;
            rate_q <= RATE_W_P'(RATE_CLKS_DEF);
        end else begin
            sync_q <= sync_d;
            standby_bit_q <= standby_bit_d;
            rate_q <= rate_d;
        end
    end

    // =========================================================================
    // Filter sequencer
    // =========================================================================
    // Held: divider stopped; the filter is in reset only while sync is set, not in standby.
    // Settle: divider running, words withheld for the settling periods.
    // Run: one word per output period.
    // The halt decision uses the next bit values so the filter stops on the
    // same edge at which the bit is seen set, never one word late.
    asr_state_t st_q, st_d;
    logic [SETTLE_W-1:0] set_q, set_d;
    logic load_q, load_d;
    logic run_q, run_d;
    logic settled_q, settled_d;
    logic halt;

    // Sync or standby both halt conversion; standby keeps the data word.
    assign halt = sync_d | standby_bit_d;

    always_comb begin
        st_d = st_q;
        set_d = set_q;
        load_d = 1'b0;
        run_d = 1'b0;
        settled_d = settled_q;
        case (st_q)
            ASR_HELD: begin
                set_d = '0;
                if (!halt) begin
                    st_d = ASR_SETTLE;
                    run_d = 1'b1;
                end
            end
            ASR_SETTLE: begin
                run_d = 1'b1;
                if (tk.tick) begin
                    if (set_q == SETTLE_W'(SETTLE_PERIODS - 1)) begin
                        st_d = ASR_RUN;
                        load_d = 1'b1;
                        settled_d = 1'b1;
                    end else begin
                        set_d = set_q + 1'b1;
                    end
                end
            end
            ASR_RUN: begin
                run_d = 1'b1;
                load_d = tk.tick;
            end
            default: begin
                st_d = ASR_HELD;
            end
        endcase
        if (halt) begin
            st_d = ASR_HELD;
            run_d = 1'b0;
            load_d = 1'b0;
            settled_d = 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            // Reset releases straight into settling with defaults.
            st_q <= ASR_SETTLE;
            set_q <= '0;
            load_q <= 1'b0;
            run_q <= 1'b1;
            settled_q <= 1'b0;
        end else begin
            st_q <= st_d;
            set_q <= set_d;
            load_q <= load_d;
            run_q <= run_d;
            settled_q <= settled_d;
        end
    end

    assign tk.run = run_q;

    // =========================================================================
    // Data-ready
    // =========================================================================
    // High: no unread word. Low: an unread word is held.
    // Pulse: a word was replaced while unread; the line stands high for the
    // pulse length so the host does not read during the update.
    // Halting does not touch a low line, since the held word stays valid.
    // A pulse that ends after a halt returns high, because the next word
    // must wait for the full settling time.
    asr_dr_t dr_q, dr_d;
    logic [PULSE_W-1:0] pul_q, pul_d;
    logic data_ready_n_q, data_ready_n_d;

    // A load while low gives the high pulse; a read raises the line. The
    // update beats a read in the same cycle so a new word is never hidden.
    always_comb begin
        dr_d = dr_q;
        pul_d = pul_q;
        case (dr_q)
            ASR_DR_HIGH: begin
                if (load_d) begin
                    dr_d = ASR_DR_LOW;
                end
            end
            ASR_DR_LOW: begin
                if (load_d) begin
                    dr_d = ASR_DR_PULSE;
                    pul_d = PULSE_W'(PULSE_CLKS_P - 1);
                end else if (i_data_read_done) begin
                    dr_d = ASR_DR_HIGH;
                end
            end
            ASR_DR_PULSE: begin
                if (pul_q != '0) begin
                    pul_d = pul_q - 1'b1;
                end else if (settled_q) begin
                    dr_d = ASR_DR_LOW;
                end else begin
                    // A halt during the pulse keeps the line high.
                    dr_d = ASR_DR_HIGH;
                end
            end
            default: begin
                dr_d = ASR_DR_HIGH;
            end
        endcase
        data_ready_n_d = (dr_d != ASR_DR_LOW);
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            dr_q <= ASR_DR_HIGH;
            pul_q <= '0;
            data_ready_n_q <= DATA_READY_N_IDLE;
        end else begin
            dr_q <= dr_d;
            pul_q <= pul_d;
            data_ready_n_q <= data_ready_n_d;
        end
    end

    // =========================================================================
    // Master clock and outputs
    // =========================================================================
    // Every output is a plain copy of a register, so nothing combinational
    // reaches the pins. The clock copy costs one cycle of delay.
    logic mclk_q;

    // The clock copy ignores reset and standby so it never stops.
    always_ff @(posedge i_clk) begin
        mclk_q <= i_mclk;
    end

    assign o_mclk = mclk_q;
    assign o_filter_reset = sync_q;
    assign o_powered_down = standby_bit_q;
    assign o_load_word = load_q;
    assign o_data_ready_n = data_ready_n_q;
    assign o_status_msb = data_ready_n_q;
    assign o_filter_sync_bit = sync_q;
    assign o_standby_bit = standby_bit_q;

endmodule : asr_ctrl

// ### src/asr_pkg.sv
package asr_pkg;

    // =========================================================================
    // Timing
    // =========================================================================

    // Master clock rate in kHz.
    localparam int unsigned CLK_KHZ = 250000;
    // Settling takes this many output-rate periods after a restart.
    localparam int unsigned SETTLE_PERIODS = 3;
    // Data-ready high pulse around an update, in master clock periods.
    localparam int unsigned UPD_PULSE_CLKS = 500;
    // Default output-rate period in master clock cycles.
    localparam int unsigned RATE_CLKS_DEF = 5000;
    // Counter widths.
    localparam int unsigned RATE_W = 24;
    localparam int unsigned PULSE_W = 10;
    localparam int unsigned SETTLE_W = 2;

    // Reset values of the control bits.
    localparam logic SYNC_RST = 1'b0;
    localparam logic STANDBY_BIT_RST = 1'b0;
    // Data-ready level while idle or in reset.
    localparam logic DATA_READY_N_IDLE = 1'b1;

    // =========================================================================
    // Filter sequencer states
    // =========================================================================
    typedef enum logic [1:0] {
        ASR_HELD = 2'b00,
        ASR_SETTLE = 2'b01,
        ASR_RUN = 2'b10
    } asr_state_t;

    // Data-ready state.
    typedef enum logic [1:0] {
        ASR_DR_HIGH = 2'b00,
        ASR_DR_LOW = 2'b01,
        ASR_DR_PULSE = 2'b10
    } asr_dr_t;

endpackage : asr_pkg

// ### src/asr_tick_if.sv
`timescale 1ns/1ns
// Output-rate tick and its control between the divider and the sequencer.
interface asr_tick_if;
    logic run;
    logic tick;
    modport src (input run, output tick);
    modport dst (output run, input tick);
endinterface : asr_tick_if

// ### src/asr_rate_div.sv
`timescale 1ns/1ns
module asr_rate_div
    import asr_pkg::*;
#(
    parameter int unsigned RATE_W_P = RATE_W
) (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Output-rate period in master clocks.
    input wire logic [RATE_W_P-1:0] i_period,
    // Tick link.
    asr_tick_if.src tk
);

    // =========================================================================
    // Output-rate divider
    // =========================================================================
    logic [RATE_W_P-1:0] cnt_q, cnt_d;
    logic tick_q, tick_d;

    initial begin
        if (RATE_W_P < 2) $error("asr_rate_div: RATE_W_P too small");
    end

    // Counting restarts from zero whenever run drops, so a restart is aligned.
    always_comb begin
        cnt_d = '0;
        tick_d = 1'b0;
        if (tk.run) begin
            if (cnt_q + 1'b1 >= i_period) begin
                tick_d = 1'b1;
            end else begin
                cnt_d = cnt_q + 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_q <= '0;
            tick_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tk.tick = tick_q;

endmodule : asr_rate_div

// ### tb/asr_ctrl_asserts.sv
`timescale 1ns/1ns
module asr_ctrl_asserts
    import asr_pkg::*;
#(
    parameter int unsigned RATE_W_P = RATE_W
) (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Watched ports.
    input wire logic i_mclk,
    input wire logic o_mclk,
    input wire logic i_ctl_we,
    input wire logic i_sync_wdata,
    input wire logic i_standby_bit_wdata,
    input wire logic [RATE_W_P-1:0] i_rate_clks,
    input wire logic i_data_read_done,
    input wire logic o_filter_reset,
    input wire logic o_powered_down,
    input wire logic o_load_word,
    input wire logic o_data_ready_n,
    input wire logic o_status_msb
);
    logic [31:0] run_q;
    logic [31:0] run_d;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    // Cycles of free running; held at zero while sync or standby halts.
    always_comb begin
        run_d = (o_filter_reset || o_powered_down) ? 32'h0 : run_q + 32'h1;
    end
    // Register the run count; reset restarts it like a release does.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            run_q <= 32'h0;
        end else begin
            run_q <= run_d;
        end
    end
    status_mirror_a: assert property (
        o_status_msb == o_data_ready_n) else $error("status bit differs");
    reset_idle_a: assert property (
        $rose(i_rst_n) |-> o_data_ready_n) else $error("ready low at reset");
    mclk_follow_a: assert property (
        o_mclk == $past(i_mclk)) else $error("clock copy broken");
    ctl_write_a: assert property (
        i_ctl_we |=> o_filter_reset == $past(i_sync_wdata)
        && o_powered_down == $past(i_standby_bit_wdata)) else $error("ctl bits");
    settle_wait_a: assert property (
        o_load_word |-> run_q + 32'h2 >= 32'(i_rate_clks) * 3)
        else $error("word loaded before settling");
    load_fall_a: assert property (
        o_load_word && $past(o_data_ready_n) |-> !o_data_ready_n)
        else $error("ready not low on new word");
    read_clear_a: assert property (
        i_data_read_done ##1 !o_load_word |-> o_data_ready_n)
        else $error("ready not high after read");
    held_high_a: assert property (
        o_filter_reset && o_data_ready_n |=> o_data_ready_n)
        else $error("ready fell while held");
endmodule : asr_ctrl_asserts

bind asr_ctrl asr_ctrl_asserts #(.RATE_W_P(RATE_W_P)) chk (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_mclk(i_mclk), .o_mclk(o_mclk),
    .i_ctl_we(i_ctl_we), .i_sync_wdata(i_sync_wdata),
    .i_standby_bit_wdata(i_standby_bit_wdata), .i_rate_clks(i_rate_clks),
    .i_data_read_done(i_data_read_done), .o_filter_reset(o_filter_reset),
    .o_powered_down(o_powered_down), .o_load_word(o_load_word),
    .o_data_ready_n(o_data_ready_n), .o_status_msb(o_status_msb)
);

// ### tb/asr_host_model.sv
`timescale 1ns/1ns
module asr_host_model (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_data_ready_n,
    // Mode 0 leaves words unread, 1 reads at once, 2 reads slowly.
    input wire logic [1:0] i_mode,
    output logic o_read_done
);
    int wait_q;
    // One read per flagged word; never reads while the word is not flagged.
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_read_done <= 1'b0;
            wait_q <= 0;
        end else if (o_read_done || i_data_ready_n !== 1'b0 || !i_mode) begin
            o_read_done <= 1'b0;
            wait_q <= 0;
        end else if (i_mode == 2'h1 || wait_q == 6) begin
            o_read_done <= 1'b1;
        end else begin
            wait_q <= wait_q + 1;
        end
    end
endmodule : asr_host_model

// ### tb/testbench.sv
`timescale 1ns/1ns
module testbench;
    import asr_pkg::*;
    logic i_clk, i_rst_n, i_mclk, i_ctl_we, i_sync_wdata, i_standby_bit_wdata;
    logic i_rate_we, rd_done, o_filter_reset, o_powered_down, o_load_word;
    logic o_data_ready_n, o_filter_sync_bit, o_standby_bit;
    logic [RATE_W-1:0] i_rate_clks;
    logic [1:0] mode;
    logic o_mclk, o_status_msb;
    localparam int PULSE_TB = 20;
    int fails, checks, seed, rate, n, k;
    asr_ctrl #(.PULSE_CLKS_P(PULSE_TB)) dut (.i_clk(i_clk),
        .i_rst_n(i_rst_n), .i_mclk(i_mclk), .o_mclk(o_mclk),
        .i_ctl_we(i_ctl_we),
        .i_sync_wdata(i_sync_wdata), .i_standby_bit_wdata(i_standby_bit_wdata),
        .i_rate_clks(i_rate_clks), .i_rate_we(i_rate_we),
        .i_data_read_done(rd_done), .o_filter_reset(o_filter_reset),
        .o_powered_down(o_powered_down), .o_load_word(o_load_word),
        .o_data_ready_n(o_data_ready_n), .o_status_msb(o_status_msb),
        .o_filter_sync_bit(o_filter_sync_bit), .o_standby_bit(o_standby_bit));
    asr_host_model host (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_data_ready_n(o_data_ready_n), .i_mode(mode), .o_read_done(rd_done));
    // Clock, and a master clock copy that toggles every cycle.
    initial begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end
    always @(posedge i_clk) i_mclk <= (i_mclk === 1'b1) ? 1'b0 : 1'b1;
    task automatic report_and_stop();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : report_and_stop
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    // Settling lasts three output periods; small slack covers pipelining.
    function automatic logic near(input int got, input int r, input int x);
        return got >= SETTLE_PERIODS * r + x - 5
            && got <= SETTLE_PERIODS * r + x + 5;
    endfunction : near
    task automatic ctl(input logic s, input logic b);
        @(posedge i_clk);
        i_ctl_we <= 1'b1;
        i_sync_wdata <= s;
        i_standby_bit_wdata <= b;
        @(posedge i_clk);
        i_ctl_we <= 1'b0;
        @(posedge i_clk);
    endtask : ctl
    // Bounded wait for a data ready level, counting cycles.
    task automatic wait_lvl(input logic lvl, output int cnt);
        cnt = 0;
        while (o_data_ready_n !== lvl && cnt < 40000) begin
            @(posedge i_clk);
            #1;
            cnt++;
        end
    endtask : wait_lvl
    // Watchdog sized for the default first conversion plus the rest.
    initial begin
        #200000;
        fails++;
        report_and_stop();
    end
    initial begin
        {i_rst_n, i_ctl_we, i_sync_wdata, i_standby_bit_wdata} = 4'h0;
        {i_rate_we, mode, fails, checks, seed} = {3'h1, 32'h0, 32'h0, 32'd38};
        i_rate_clks = RATE_W'(RATE_CLKS_DEF);
        repeat (10) @(posedge i_clk);
        check(o_data_ready_n, 1'b1);
        i_rst_n <= 1'b1;
        wait_lvl(1'b0, n);
        check(near(n, RATE_CLKS_DEF, 0), 1'b1);
        $display("test 1 done");
        // Periods longer than the pulse, so no word lands inside a pulse.
        rate = PULSE_TB + 4 + ($random(seed) & 7);
        @(posedge i_clk);
        i_rate_clks <= RATE_W'(rate);
        i_rate_we <= 1'b1;
        @(posedge i_clk);
        i_rate_we <= 1'b0;
        wait_lvl(1'b1, n);
        ctl(1'b1, 1'b0);
        repeat (5) @(posedge i_clk);
        mode <= 2'h0;
        check(o_filter_sync_bit, 1'b1);
        check(o_data_ready_n, 1'b1);
        ctl(1'b0, 1'b0);
        wait_lvl(1'b0, n);
        check(near(n, rate, 0), 1'b1);
        $display("test 2 done");
        ctl(1'b1, 1'b0);
        ctl(1'b0, 1'b0);
        check(o_data_ready_n, 1'b0);
        wait_lvl(1'b1, n);
        wait_lvl(1'b0, n);
        check(n, PULSE_TB);
        $display("test 3 done");
        ctl(1'b0, 1'b1);
        k = 0;
        repeat (4 * rate) begin
            @(posedge i_clk);
            #1;
            k += int'(o_load_word === 1'b1);
        end
        check(k, 0);
        check({o_standby_bit, o_data_ready_n}, 2'h2);
        mode <= 2'h2;
        repeat (12) @(posedge i_clk);
        check(o_data_ready_n, 1'b1);
        mode <= 2'h0;
        ctl(1'b0, 1'b0);
        wait_lvl(1'b0, n);
        check(near(n, rate, 0), 1'b1);
        $display("test 4 done");
        repeat (8) begin
            mode <= 2'($random(seed));
            ctl(1'($random(seed)), 1'($random(seed)));
            repeat (2 * rate + ($random(seed) & 15)) @(posedge i_clk);
        end
        $display("test 5 done");
        i_rst_n <= 1'b0;
        repeat (3) @(posedge i_clk);
        #1;
        check({o_data_ready_n, o_standby_bit, o_filter_sync_bit},
            3'h4);
        check(o_mclk, 1'(~i_mclk));
        check(o_status_msb, o_data_ready_n);
        @(posedge i_clk);
        i_rst_n <= 1'b1;
        wait_lvl(1'b0, n);
        check(near(n, RATE_CLKS_DEF, 0), 1'b1);
        $display("test 6 done");
        report_and_stop();
    end
endmodule : testbench
